//--- src/gdfr_controller.sv
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module gdfr_controller #(
   parameter int unsigned CLK_HZ = gdfr_pkg::CLK_HZ,
   parameter int unsigned RAIL_WAIT_CYC =
      gdfr_pkg::RAIL_WAIT_MS * (CLK_HZ / gdfr_pkg::MS_PER_S),
   parameter int unsigned CP_WAIT_CYC =
      gdfr_pkg::CP_WAIT_MS * (CLK_HZ / gdfr_pkg::MS_PER_S),
   parameter int unsigned MAX_RETRY = gdfr_pkg::MAX_RETRY
) (
   // Clock and reset.
   input  wire logic                aclk,
   input  wire logic                aresetn,
   // AXI4-Lite write channels.
   input  wire logic                awvalid,
   output logic                     awready,
   input  wire gdfr_pkg::axi_addr_t awaddr,
   input  wire logic [2:0]          awprot,
   input  wire logic                wvalid,
   output logic                     wready,
   input  wire logic [31:0]         wdata,
   input  wire logic [3:0]          wstrb,
   output logic                     bvalid,
   input  wire logic                bready,
   output logic [1:0]               bresp,
   // AXI4-Lite read channels.
   input  wire logic                arvalid,
   output logic                     arready,
   input  wire gdfr_pkg::axi_addr_t araddr,
   input  wire logic [2:0]          arprot,
   output logic                     rvalid,
   input  wire logic                rready,
   output logic [31:0]              rdata,
   output logic [1:0]               rresp,
   // Motor control PWM request.
   input  wire logic [5:0]          pwm_in,
   // Link to the driver.
   gdfr_if.controller               link
);
   import gdfr_pkg::*;

   typedef struct packed {
      logic        aw_got;
      axi_addr_t   waddr;
      logic        w_got;
      logic [31:0] wd;
      logic [3:0]  ws;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        en;
      logic        pend;
      logic [2:0]  app_oe_n;
      logic [2:0]  app_out;
      seq_state_t  st;
      result_t     res;
      logic [2:0]  retries;
      logic [31:0] cnt;
      logic [1:0]  idx;
      logic [31:0] grp;
      logic        block;
      logic        cmp_in;
      logic        req;
      logic        we;
      dev_addr_t   addr;
      logic [7:0]  wdat;
      logic [5:0]  gate;
      logic [2:0]  cmp_oe_n;
      logic [2:0]  cmp_out;
   } ctl_state_t;

   ctl_state_t s;
   ctl_state_t next_s;
   logic       set_pend;
   logic       busy;
   logic [31:0] status_word;

   assign busy = (s.st != S_IDLE);
   assign status_word = {20'h00000, link.fault_indicator_n, s.retries,
                         busy, s.res, s.st};

   // Handshake readiness of the register bus.
   assign awready = ~s.aw_got & ~s.bvalid;
   assign wready  = ~s.w_got & ~s.bvalid;
   assign arready = ~s.rvalid;

   // Bus slave, then the recovery sequencer.
   always_comb begin
      next_s   = s;
      set_pend = 1'b0;
      if (awvalid && awready) begin
         next_s.aw_got = 1'b1;
         next_s.waddr  = awaddr;
      end
      if (wvalid && wready) begin
         next_s.w_got = 1'b1;
         next_s.wd    = wdata;
         next_s.ws    = wstrb;
      end
      if (s.bvalid && bready) next_s.bvalid = 1'b0;
      if (s.aw_got && s.w_got && !s.bvalid) begin
         next_s.aw_got = 1'b0;
         next_s.w_got  = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp  = RESP_OKAY;
         case (s.waddr)
            A_CTRL: if (s.ws[0]) begin
               next_s.en = s.wd[C_DRIVE_EN];
               set_pend  = s.wd[C_ERR_EVENT];
            end
            A_CMP_APP: if (s.ws[0]) begin
               next_s.app_oe_n = s.wd[CA_OE_LO +: 3];
               next_s.app_out  = s.wd[CA_OUT_LO +: 3];
            end
            A_STATUS, A_FAULTS: next_s.bresp = RESP_OKAY;
            default: next_s.bresp = RESP_SLVERR;
         endcase
      end
      if (s.rvalid && rready) next_s.rvalid = 1'b0;
      if (arvalid && arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp  = RESP_OKAY;
         case (araddr)
            A_CTRL:    next_s.rdata = {31'h0, s.en};
            A_STATUS:  next_s.rdata = status_word;
            A_FAULTS:  next_s.rdata = s.grp;
            A_CMP_APP: next_s.rdata = {25'h0, s.app_out, 1'b0, s.app_oe_n};
            default: begin
               next_s.rdata = 32'h0;
               next_s.rresp = RESP_SLVERR;
            end
         endcase
      end
      // An event during the take is kept: set wins over clear.
      if (set_pend) next_s.pend = 1'b1;

      case (s.st)
         S_IDLE: if (s.pend) begin
            next_s.pend    = set_pend;
            next_s.retries = 3'h0;
            next_s.res     = RES_NONE;
            next_s.st      = S_CHECK_EN;
         end
         S_CHECK_EN: begin
            if (!s.en) begin
               next_s.res = RES_NONRECOV;
               next_s.st  = S_IDLE;
            end else begin
               next_s.idx = 2'h0;
               next_s.st  = S_NEXT;
            end
         end
         S_NEXT: begin
            next_s.req  = 1'b1;
            next_s.we   = 1'b0;
            next_s.addr = dev_addr_t'(s.idx);
            next_s.st   = S_READ;
         end
         S_READ: if (link.reg_ack) begin
            next_s.req = 1'b0;
            next_s.grp[8*s.idx +: 8] = link.reg_rdata;
            next_s.idx = s.idx + 2'h1;
            next_s.st  = S_NEXT;
            if (s.idx == 2'h0) begin
               if (!link.reg_rdata[G0_SUMMARY]) begin
                  next_s.res = RES_EXTERNAL;
                  next_s.st  = S_IDLE;
               end else begin
                  next_s.block  = 1'b1;
                  next_s.cmp_in = 1'b1;
               end
            end else if (s.idx == 2'h3) begin
               next_s.st = S_CLASSIFY;
            end
         end
         S_CLASSIFY: begin
            // Latched first, then rail restart, then self-recovering.
            if (|s.grp[24 +: FC_W]) begin
               next_s.en  = 1'b0;
               next_s.res = RES_OVERCURRENT;
               next_s.st  = S_IDLE;
            end else if (s.grp[16+G2_REG_OC] || s.grp[16+G2_RAIL_UV]) begin
               next_s.cnt = 32'(RAIL_WAIT_CYC);
               next_s.st  = S_WAIT;
            end else if (s.grp[16+G2_CP_UV]) begin
               next_s.cnt = 32'(CP_WAIT_CYC);
               next_s.st  = S_WAIT;
            end else begin
               next_s.st = S_CONFIRM;
            end
         end
         S_CONFIRM: begin
            if (link.fault_indicator_n) begin
               next_s.st = S_CLEAR;
            end else begin
               next_s.res = RES_RETRY_LATER;
               next_s.st  = S_IDLE;
            end
         end
         S_WAIT: begin
            if (s.cnt <= 32'h1) next_s.st = S_CHECK_B;
            else next_s.cnt = s.cnt - 32'h1;
         end
         S_CHECK_B: begin
            if (link.fault_indicator_n) begin
               next_s.st = S_CLEAR;
            end else if (32'(s.retries) + 32'h1 >= 32'(MAX_RETRY)) begin
               next_s.en  = 1'b0;
               next_s.res = RES_REGULATOR;
               next_s.st  = S_IDLE;
            end else begin
               next_s.retries = s.retries + 3'h1;
               next_s.cnt = s.grp[16+G2_CP_UV] &&
                            !(s.grp[16+G2_REG_OC] || s.grp[16+G2_RAIL_UV]) ?
                            32'(CP_WAIT_CYC) : 32'(RAIL_WAIT_CYC);
               next_s.st = S_WAIT;
            end
         end
         S_CLEAR: begin
            next_s.req  = 1'b1;
            next_s.we   = 1'b1;
            next_s.addr = DA_IC_CTL1;
            next_s.wdat = 8'(1 << CTL1_CLEAR);
            next_s.st   = S_CLR_WAIT;
         end
         S_CLR_WAIT: if (link.reg_ack) begin
            next_s.req    = 1'b0;
            next_s.we     = 1'b0;
            next_s.block  = 1'b0;
            next_s.cmp_in = 1'b0;
            next_s.res    = RES_RECOVERED;
            next_s.st     = S_IDLE;
         end
         default: next_s.st = S_IDLE;
      endcase

      // Pin drive follows the next state so it is never a cycle stale.
      next_s.gate     = next_s.block ? 6'h00 : pwm_in;
      next_s.cmp_oe_n = next_s.cmp_in ? CMP_ALL_INPUT : next_s.app_oe_n;
      next_s.cmp_out  = next_s.app_out;
   end

   // State register.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
         s.app_oe_n <= CMP_ALL_INPUT;
         s.cmp_oe_n <= CMP_ALL_INPUT;
         s.st       <= S_IDLE;
         s.res      <= RES_NONE;
      end else begin
         s <= next_s;
      end
   end

   // Outputs from the state register.
   assign bvalid                = s.bvalid;
   assign bresp                 = s.bresp;
   assign rvalid                = s.rvalid;
   assign rdata                 = s.rdata;
   assign rresp                 = s.rresp;
   assign link.enable           = s.en;
   assign link.gate_drive_input = s.gate;
   assign link.cmp_ctl_oe_n     = s.cmp_oe_n;
   assign link.cmp_ctl_out      = s.cmp_out;
   assign link.reg_req          = s.req;
   assign link.reg_we           = s.we;
   assign link.reg_addr         = s.addr;
   assign link.reg_wdata        = s.wdat;

endmodule // gdfr_controller

//--- src/gdfr_driver.sv
`timescale 1ns/1ps
module gdfr_driver #(
   parameter int unsigned CLK_HZ     = gdfr_pkg::CLK_HZ,
   parameter int unsigned HICCUP_CYC =
      gdfr_pkg::HICCUP_MS * (CLK_HZ / gdfr_pkg::MS_PER_S)
) (
   // Clock and reset.
   input  wire logic                         aclk,
   input  wire logic                         aresetn,
   // Link to the controller.
   gdfr_if.device                            link,
   // Fault conditions and comparator results from the analog side.
   input  wire logic [gdfr_pkg::FAULT_W-1:0] fault_cond,
   input  wire logic [2:0]                   cmp_result,
   // Gate drive and mode.
   output logic [5:0]                        gate_out,
   output logic                              operating
);
   import gdfr_pkg::*;

   typedef struct packed {
      logic [7:0]  grp1;
      logic [7:0]  grp2;
      logic [7:0]  grp3;
      logic [7:1]  ctl1;
      logic        clr;
      logic        latched;
      logic        hiccup;
      logic [31:0] hic_cnt;
      logic        oper;
      logic        ack;
      logic [7:0]  rdata;
      logic [5:0]  gate;
      logic [2:0]  cmp_out;
      logic [2:0]  cmp_oe_n;
   } drv_state_t;

   drv_state_t s;
   drv_state_t next_s;
   logic [7:0] grp0;
   logic       rail_trig;
   logic       fault_act;

   // Summary group is built from the three detail groups.
   assign grp0 = {(|s.grp1) | (|s.grp2) | (|s.grp3), 4'h0,
                  |s.grp3, |s.grp2, |s.grp1};
   assign rail_trig = fault_cond[FB_LO+G2_REG_OC] |
                      fault_cond[FB_LO+G2_RAIL_UV];

   // Status, recovery and register port behaviour.
   always_comb begin
      next_s = s;
      // Set wins over the clear-fault action.
      next_s.grp1 = (s.clr ? 8'h00 : s.grp1) |
                    {3'h0, fault_cond[FA_LO +: FA_W]};
      next_s.grp2 = (s.clr ? 8'h00 : s.grp2) |
                    {5'h00, fault_cond[FB_LO +: FB_W]};
      next_s.grp3 = (s.clr ? 8'h00 : s.grp3) |
                    {5'h00, fault_cond[FC_LO +: FC_W]};
      next_s.clr = 1'b0;
      // Regulator restarts after a full dummy cycle while a trigger holds.
      if (!s.hiccup) begin
         if (rail_trig) begin
            next_s.hiccup  = 1'b1;
            next_s.hic_cnt = 32'h0;
         end
      end else if (s.hic_cnt == 32'(HICCUP_CYC - 1)) begin
         if (rail_trig) next_s.hic_cnt = 32'h0;
         else next_s.hiccup = 1'b0;
      end else begin
         next_s.hic_cnt = s.hic_cnt + 32'h1;
      end
      // Latched faults hold fault mode until the driver is disabled.
      next_s.latched = s.latched | (|fault_cond[FC_LO +: FC_W]);
      // Charge pump fault clears with its condition, no restart cycle.
      fault_act = (|fault_cond[FA_LO +: FA_W]) | rail_trig |
                  next_s.hiccup | fault_cond[FB_LO+G2_CP_UV] |
                  next_s.latched;
      next_s.oper = link.enable & ~fault_act;
      // Register port answers one cycle after a new request.
      next_s.ack = link.reg_req & ~s.ack;
      if (link.reg_req && !s.ack) begin
         case (link.reg_addr)
            DA_STATUS0: next_s.rdata = grp0;
            DA_STATUS1: next_s.rdata = s.grp1;
            DA_STATUS2: next_s.rdata = s.grp2;
            DA_STATUS3: next_s.rdata = s.grp3;
            DA_IC_CTL1: next_s.rdata = {s.ctl1, s.clr};
            default:    next_s.rdata = 8'h00;
         endcase
         if (link.reg_we && link.reg_addr == DA_IC_CTL1) begin
            next_s.ctl1 = link.reg_wdata[7:1];
            next_s.clr  = link.reg_wdata[CTL1_CLEAR];
         end
      end
      // A disabled driver sleeps and forgets all fault state.
      if (!link.enable) begin
         next_s.grp1    = 8'h00;
         next_s.grp2    = 8'h00;
         next_s.grp3    = 8'h00;
         next_s.ctl1    = 7'h00;
         next_s.clr     = 1'b0;
         next_s.latched = 1'b0;
         next_s.hiccup  = 1'b0;
         next_s.hic_cnt = 32'h0;
      end
      next_s.gate     = next_s.oper ? link.gate_drive_input : 6'h00;
      next_s.cmp_out  = cmp_result;
      next_s.cmp_oe_n = link.enable ? 3'h0 : CMP_ALL_INPUT;
   end

   // State register.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
         s.cmp_oe_n <= CMP_ALL_INPUT;
      end else begin
         s <= next_s;
      end
   end

   // Outputs come straight from the state register.
   assign link.fault_indicator_n = s.oper;
   assign link.reg_ack           = s.ack;
   assign link.reg_rdata         = s.rdata;
   assign link.cmp_dev_out       = s.cmp_out;
   assign link.cmp_dev_oe_n      = s.cmp_oe_n;
   assign gate_out               = s.gate;
   assign operating              = s.oper;

endmodule // gdfr_driver

//--- src/gdfr_if.sv
`timescale 1ns/1ps
interface gdfr_if;
   logic                enable;
   logic [5:0]          gate_drive_input;
   logic                fault_indicator_n;
   logic [2:0]          cmp_dev_out;
   logic [2:0]          cmp_dev_oe_n;
   logic [2:0]          cmp_ctl_out;
   logic [2:0]          cmp_ctl_oe_n;
   logic [2:0]          comparator_out_pin;
   logic                reg_req;
   logic                reg_we;
   gdfr_pkg::dev_addr_t reg_addr;
   logic [7:0]          reg_wdata;
   logic [7:0]          reg_rdata;
   logic                reg_ack;

   // Wire level of each comparator pin; an undriven pin reads high.
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         if (!cmp_dev_oe_n[i]) comparator_out_pin[i] = cmp_dev_out[i];
         else if (!cmp_ctl_oe_n[i]) comparator_out_pin[i] = cmp_ctl_out[i];
         else comparator_out_pin[i] = 1'b1;
      end
   end

   modport device (
      input  enable, gate_drive_input, cmp_ctl_out, cmp_ctl_oe_n,
      input  comparator_out_pin, reg_req, reg_we, reg_addr, reg_wdata,
      output fault_indicator_n, cmp_dev_out, cmp_dev_oe_n,
      output reg_rdata, reg_ack
   );

   modport controller (
      output enable, gate_drive_input, cmp_ctl_out, cmp_ctl_oe_n,
      output reg_req, reg_we, reg_addr, reg_wdata,
      input  fault_indicator_n, cmp_dev_out, cmp_dev_oe_n,
      input  comparator_out_pin, reg_rdata, reg_ack
   );
endinterface

//--- src/gdfr_pkg.sv
package gdfr_pkg;

   // Clock and timing figures.
   localparam int unsigned CLK_HZ       = 50_000_000;
   localparam int unsigned MS_PER_S     = 1000;
   localparam int unsigned HICCUP_MS    = 63;
   localparam int unsigned RAIL_WAIT_MS = 150;
   localparam int unsigned CP_WAIT_MS   = 150;
   localparam int unsigned MAX_RETRY    = 5;

   // Fault condition vector: class a, class b, class c slices.
   localparam int FAULT_W = 11;
   localparam int FA_LO   = 0;
   localparam int FA_W    = 5;
   localparam int FB_LO   = 5;
   localparam int FB_W    = 3;
   localparam int FC_LO   = 8;
   localparam int FC_W    = 3;

   // Bits inside the status groups.
   localparam int G0_CLS_A   = 0;
   localparam int G0_CLS_B   = 1;
   localparam int G0_CLS_C   = 2;
   localparam int G0_SUMMARY = 7;
   localparam int G2_CP_UV   = 0;
   localparam int G2_REG_OC  = 1;
   localparam int G2_RAIL_UV = 2;
   localparam int CTL1_CLEAR = 0;

   // Driver register port addresses.
   typedef logic [2:0] dev_addr_t;
   localparam dev_addr_t DA_STATUS0 = 3'h0;
   localparam dev_addr_t DA_STATUS1 = 3'h1;
   localparam dev_addr_t DA_STATUS2 = 3'h2;
   localparam dev_addr_t DA_STATUS3 = 3'h3;
   localparam dev_addr_t DA_IC_CTL1 = 3'h4;

   // Controller registers on AXI4-Lite.
   typedef logic [3:0] axi_addr_t;
   localparam axi_addr_t A_CTRL    = 4'h0;
   localparam axi_addr_t A_STATUS  = 4'h4;
   localparam axi_addr_t A_FAULTS  = 4'h8;
   localparam axi_addr_t A_CMP_APP = 4'hc;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int C_DRIVE_EN  = 0;
   localparam int C_ERR_EVENT = 1;
   localparam int CA_OE_LO    = 0;
   localparam int CA_OUT_LO   = 4;
   localparam int ST_STATE_LO = 0;
   localparam int ST_RESULT_LO = 4;
   localparam int ST_BUSY     = 7;
   localparam int ST_RETRY_LO = 8;
   localparam int ST_FAULT_N  = 11;
   localparam logic [2:0] CMP_ALL_INPUT = 3'h7;

   typedef enum logic [3:0] {
      S_IDLE     = 4'b0000,
      S_CHECK_EN = 4'b0001,
      S_NEXT     = 4'b0010,
      S_READ     = 4'b0011,
      S_CLASSIFY = 4'b0100,
      S_CONFIRM  = 4'b0101,
      S_WAIT     = 4'b0110,
      S_CHECK_B  = 4'b0111,
      S_CLEAR    = 4'b1000,
      S_CLR_WAIT = 4'b1001
   } seq_state_t;

   typedef enum logic [2:0] {
      RES_NONE        = 3'b000,
      RES_NONRECOV    = 3'b001,
      RES_EXTERNAL    = 3'b010,
      RES_RECOVERED   = 3'b011,
      RES_RETRY_LATER = 3'b100,
      RES_REGULATOR   = 3'b101,
      RES_OVERCURRENT = 3'b110
   } result_t;

endpackage

//--- test/gate_driver_fault_recovery_seq_test.sv
`timescale 1ns/1ps
module gate_driver_fault_recovery_seq_test;
   import gdfr_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
   logic rready = 1'b0, awready, wready, bvalid, arready, rvalid;
   axi_addr_t awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, st;
   logic [1:0] bresp, rresp;
   logic [5:0] pwm_in = 6'h2d, gate_out;
   logic [FAULT_W-1:0] fault_cond = '0;
   logic operating;
   logic [3:0] wstrb = 4'hf;
   logic [2:0] cmp_result = 3'h5;
   int failures = 0, checked = 0;
   gdfr_if i_gdfr_if ();
   gdfr_driver #(.HICCUP_CYC(20)) i_gdfr_driver (.aclk(aclk),
      .aresetn(aresetn), .link(i_gdfr_if), .fault_cond(fault_cond),
      .cmp_result(cmp_result), .gate_out(gate_out), .operating(operating));
   gdfr_controller #(.RAIL_WAIT_CYC(50), .CP_WAIT_CYC(50)) i_gdfr_controller (
      .aclk(aclk), .aresetn(aresetn),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
      .rready(rready), .rdata(rdata), .rresp(rresp), .pwm_in(pwm_in),
      .link(i_gdfr_if));
   gdfr_sva i_gdfr_sva (.aclk(aclk), .aresetn(aresetn),
      .enable(i_gdfr_if.enable), .gate_drive_input(i_gdfr_if.gate_drive_input),
      .fault_indicator_n(i_gdfr_if.fault_indicator_n),
      .cmp_ctl_oe_n(i_gdfr_if.cmp_ctl_oe_n), .reg_req(i_gdfr_if.reg_req),
      .reg_we(i_gdfr_if.reg_we), .reg_addr(i_gdfr_if.reg_addr),
      .reg_wdata(i_gdfr_if.reg_wdata), .reg_rdata(i_gdfr_if.reg_rdata),
      .reg_ack(i_gdfr_if.reg_ack));

   // A 50 MHz clock.
   always #10 aclk = ~aclk;

   // Compares one value and counts the outcome.
   task automatic chk(input string nm, input logic [31:0] s, e);
      checked++;
      if (s !== e) begin
         failures++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask

   // One AXI4-Lite write; handshakes are judged on values settled mid-cycle.
   task automatic axi_wr(input axi_addr_t a, input logic [31:0] d,
                         input logic [1:0] er);
      logic ah, wh, at, wt;
      ah = 1'b0;
      wh = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(ah && wh)) begin
         @(negedge aclk);
         at = awvalid && awready;
         wt = wvalid && wready;
         @(posedge aclk);
         if (at) awvalid <= 1'b0;
         if (wt) wvalid <= 1'b0;
         ah = ah | at;
         wh = wh | wt;
      end
      bready <= 1'b1;
      do @(negedge aclk); while (!bvalid);
      @(posedge aclk);
      bready <= 1'b0;
      chk("bresp", 32'(bresp), 32'(er));
   endtask

   // One AXI4-Lite read returning the data.
   task automatic axi_rd(input axi_addr_t a, input logic [1:0] er,
                         output logic [31:0] d);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge aclk); while (!arready);
      @(posedge aclk);
      arvalid <= 1'b0;
      do @(negedge aclk); while (!rvalid);
      d = rdata;
      chk("rresp", 32'(rresp), 32'(er));
      @(posedge aclk);
      rready <= 1'b0;
   endtask

   // Signals an error event and polls until the sequence is over.
   task automatic run_ev(input logic en, output logic [31:0] s);
      axi_wr(A_CTRL, {30'h0, 1'b1, en}, RESP_OKAY);
      s = 32'h80;
      while (s[ST_BUSY]) axi_rd(A_STATUS, RESP_OKAY, s);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // Cuts a hang short.
   initial begin
      repeat (60000) @(posedge aclk);
      failures++;
      report_and_stop();
   end

   // Main sequence.
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(A_STATUS, RESP_OKAY, st);
      chk("status", st, 32'h0);
      axi_rd(A_CMP_APP, RESP_OKAY, st);
      chk("cmp_app", st, 32'h7);
      // A write without its low byte lane must leave the register alone.
      wstrb <= 4'he;
      axi_wr(A_CMP_APP, 32'h56, RESP_OKAY);
      axi_rd(A_CMP_APP, RESP_OKAY, st);
      chk("cmp_app_strobe", st, 32'h7);
      wstrb <= 4'hf;
      axi_rd(4'h2, RESP_SLVERR, st);
      axi_wr(4'h2, 32'h1, RESP_SLVERR);
      run_ev(1'b0, st);
      chk("result", 32'(st[6:4]), 32'(RES_NONRECOV));
      axi_wr(A_CMP_APP, 32'h56, RESP_OKAY);
      axi_wr(A_CTRL, 32'h1, RESP_OKAY);
      run_ev(1'b1, st);
      chk("result", 32'(st[6:4]), 32'(RES_EXTERNAL));
      chk("gates", 32'(i_gdfr_if.gate_drive_input), 32'(pwm_in));
      for (int i = 0; i < FAULT_W; i++) begin
         fault_cond <= FAULT_W'(1) << i;
         cmp_result <= 3'(i);
         repeat (3) @(posedge aclk);
         run_ev(1'b1, st);
         if (i < FB_LO) begin
            chk("result", 32'(st[6:4]), 32'(RES_RETRY_LATER));
         end else if (i < FC_LO) begin
            chk("result", 32'(st[6:4]), 32'(RES_REGULATOR));
            chk("retry", 32'(st[10:8]), MAX_RETRY - 1);
         end else begin
            chk("result", 32'(st[6:4]), 32'(RES_OVERCURRENT));
         end
         chk("gates", 32'(i_gdfr_if.gate_drive_input), 32'h0);
         fault_cond <= '0;
         axi_wr(A_CTRL, 32'h1, RESP_OKAY);
         run_ev(1'b1, st);
         chk("result", 32'(st[6:4]), i < FB_LO ? 32'(RES_RECOVERED) :
            32'(RES_EXTERNAL));
         repeat (2) @(posedge aclk);
         if (i < FB_LO) begin
            chk("gate_out", 32'(gate_out), 32'(pwm_in));
            chk("operating", 32'(operating), 32'h1);
            chk("cmp_pin", 32'(i_gdfr_if.comparator_out_pin), 32'(i));
            chk("cmp_oe", 32'(i_gdfr_if.cmp_ctl_oe_n), 32'h6);
         end
      end
      fault_cond <= FAULT_W'(1) << (FB_LO + 1);
      repeat (2) @(posedge aclk);
      fault_cond <= '0;
      run_ev(1'b1, st);
      chk("result", 32'(st[6:4]), 32'(RES_RECOVERED));
      chk("retry", 32'(st[10:8]), 32'h0);
      report_and_stop();
   end
endmodule // gate_driver_fault_recovery_seq_test

//--- test/gdfr_sva.sv
`timescale 1ns/1ps
module gdfr_sva (
   // Clock and reset.
   input wire logic                aclk,
   input wire logic                aresetn,
   // Link signals.
   input wire logic                enable,
   input wire logic [5:0]          gate_drive_input,
   input wire logic                fault_indicator_n,
   input wire logic [2:0]          cmp_ctl_oe_n,
   input wire logic                reg_req,
   input wire logic                reg_we,
   input wire gdfr_pkg::dev_addr_t reg_addr,
   input wire logic [7:0]          reg_wdata,
   input wire logic [7:0]          reg_rdata,
   input wire logic                reg_ack
);
   import gdfr_pkg::*;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Answered reads of the summary group and of the latched group.
   wire logic rd0 = reg_ack && !reg_we && reg_addr == DA_STATUS0;
   wire logic rd3 = reg_ack && !reg_we && reg_addr == DA_STATUS3;

   property p_ack_pulse; reg_ack |=> !reg_ack; endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("register answer longer than one cycle");
   property p_req_hold; reg_req && !reg_ack |=> reg_req && $stable(reg_addr);
   endproperty
   a_req_hold: assert property (p_req_hold)
      else $error("register request dropped before its answer");
   property p_req_en; reg_req |-> enable; endproperty
   a_req_en: assert property (p_req_en)
      else $error("register access with the driver disabled");
   property p_block;
      rd0 && reg_rdata[G0_SUMMARY] |->
         ##[1:16] (gate_drive_input == 6'h0 && cmp_ctl_oe_n == CMP_ALL_INPUT);
   endproperty
   a_block: assert property (p_block)
      else $error("gates or comparator pins not released after a fault");
   property p_latched; rd3 && reg_rdata[2:0] != 3'h0 |-> !fault_indicator_n;
   endproperty
   a_latched: assert property (p_latched)
      else $error("operating with a latched fault present");
   property p_stop_c; rd3 && reg_rdata[2:0] != 3'h0 |-> ##[1:8] !enable;
   endproperty
   a_stop_c: assert property (p_stop_c)
      else $error("driver not stopped after a latched fault");
   property p_clear_ok;
      reg_req && reg_we && reg_addr == DA_IC_CTL1 && reg_wdata[CTL1_CLEAR]
         |-> fault_indicator_n;
   endproperty
   a_clear_ok: assert property (p_clear_ok)
      else $error("status cleared while the driver is not operating");
   property p_off_low; $fell(enable) |=> !fault_indicator_n; endproperty
   a_off_low: assert property (p_off_low)
      else $error("fault indicator high after the driver was stopped");
endmodule // gdfr_sva
